/* File: design/pssd_top.sv */
// soft-strap capture, eeprom override and derived reset defaults for ports 1 and 2
//
// Function
// RULE_01: port1 rate strap default one, feeds rate bits
// RULE_02: port1 duplex strap default one, feeds duplex
// RULE_03: port1 backpressure strap loads backpressure enable
// RULE_04: port1 pause strap loads tx, rx pause
// RULE_05: pause strap influences asymmetric pause advert
// RULE_06: manual pause strap default zero, loads select
// RULE_07: manual pause strap shapes both pause adverts
// RULE_08: port2 crossover pin latched into hardware config
// RULE_09: crossover straps used only under strap control
// RULE_10: manual crossover strap forces straight or crossed
// RULE_11: port2 negotiation strap default one, loads enable
// RULE_12: latch at reset release, eeprom values override
// RULE_13: reload without eeprom reverts to latched values
// RULE_14: pins never resampled by reload or digital reset
// RULE_15: latched straps stable, applied before bus access
//
// Chosen here: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`include "pssd_defines.svh"
`default_nettype none
module pssd_top (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic port2_crossover_strap_pin,
   input wire logic eeprom_present,
   input wire logic eeprom_erased,
   input wire logic eeprom_load_valid,
   input wire pssd_pkg::pssd_strap_t eeprom_straps,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output pssd_pkg::pssd_defaults_t port_defaults,
   output logic straps_ready
);
   import pssd_pkg::*;

   // reset release chain
   logic [1:0] rst_sync;
   // synchronised active-low reset used everywhere else
   wire rst_n = rst_sync[1];
   // pin synchroniser stages
   logic pin_meta;
   logic pin_sync;
   // capture sequence state and settle counter
   pssd_state_t state;
   pssd_state_t next_state;
   logic [1:0] settle_cnt;
   // values latched at reset release, never rewritten afterwards
   pssd_strap_t latched;
   // values in force now: latched or eeprom supplied
   pssd_strap_t effective;
   // true when the eeprom copy is in force
   logic eeprom_active;
   // software control bits
   logic xsrc_register;
   logic xreg_auto;
   logic xreg_cross;
   // bus request in flight
   wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o && (state == PSSD_RUN);
   // writes land at the edge that samples ack high, while the master still holds them
   // so a write and its acknowledge are seen by both sides at the same edge
   wire bus_wr_go = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
   wire bus_wr = bus_wr_go && wb_sel_i[0];
   wire bus_wr_hi = bus_wr_go && wb_sel_i[1];
   // address decode
   wire sel_ctrl = (wb_adr_i == `PSSD_CTRL_OFS);
   wire sel_status = (wb_adr_i == `PSSD_STATUS_OFS);
   wire sel_defaults = (wb_adr_i == `PSSD_DEFAULTS_OFS);
   wire sel_latched = (wb_adr_i == `PSSD_LATCHED_OFS);
   // self-clearing reload and digital reset commands
   wire reload_cmd = bus_wr_hi && sel_ctrl && wb_dat_i[`PSSD_CTRL_RELOAD_BIT];
   wire digrst_cmd = bus_wr_hi && sel_ctrl && wb_dat_i[`PSSD_CTRL_DIGRST_BIT];
   wire refresh_cmd = reload_cmd || digrst_cmd;
   // a usable eeprom image exists
   wire eeprom_usable = eeprom_present && !eeprom_erased;

   // fresh strap set from tie-offs and the synchronised pin
   function automatic pssd_strap_t sample_straps(input logic pin);
      pssd_strap_t s;
      s.p1_speed = `PSSD_P1_SPEED_DEF;
      s.p1_duplex = `PSSD_P1_DUPLEX_DEF;
      s.p1_autoneg = `PSSD_P1_AUTONEG_DEF;
      s.port1_backpressure_default = `PSSD_P1_BP_DEF;
      s.port1_pause_enable_default = `PSSD_P1_PAUSE_DEF;
      s.port1_manual_pause_default = `PSSD_P1_MANUAL_DEF;
      s.p2_auto_crossover = pin;
      s.p2_manual_crossover = `PSSD_P2_MANUAL_X_DEF;
      s.p2_autoneg = `PSSD_P2_AUTONEG_DEF;
      return s;
   endfunction

   // reset synchroniser: async assert, two-flop release
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'h1};
      end
   end

   // pin synchroniser, first stage read only by the second
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta <= 1'h0;
         pin_sync <= 1'h0;
      end else begin
         pin_meta <= port2_crossover_strap_pin;
         pin_sync <= pin_meta;
      end
   end

   // sequence: settle the synchroniser, latch once, then run
   always_comb begin
      next_state = state;
      case (state)
         PSSD_SETTLE: begin
            if (settle_cnt == `PSSD_SETTLE_CYCLES) begin
               next_state = PSSD_LATCH;
            end
         end
         PSSD_LATCH: next_state = PSSD_RUN;
         PSSD_RUN: next_state = PSSD_RUN;
         default: next_state = PSSD_SETTLE;
      endcase
   end

   // state register and settle counter
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= PSSD_SETTLE;
         settle_cnt <= 2'h0;
      end else begin
         state <= next_state;
         if (state == PSSD_SETTLE) begin
            settle_cnt <= settle_cnt + 2'h1;
         end
      end
   end

   // latch straps only in the latch step after reset release
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         latched <= '0;
      end else if (state == PSSD_LATCH) begin // see RULE_12 see RULE_14 see RULE_15
         latched <= sample_straps(pin_sync); // see RULE_08
      end
   end

   // effective set: latched copy, eeprom override, or revert on refresh
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         effective <= '0;
         eeprom_active <= 1'h0;
      end else if (state == PSSD_LATCH) begin
         effective <= sample_straps(pin_sync);
         eeprom_active <= 1'h0;
      end else if (state == PSSD_RUN && eeprom_load_valid && eeprom_usable) begin
         effective <= eeprom_straps; // see RULE_12
         eeprom_active <= 1'h1;
      // a load pulse beats a refresh command in the same cycle
      end else if (refresh_cmd && !eeprom_usable) begin
         effective <= latched; // see RULE_13 see RULE_14
         eeprom_active <= 1'h0;
      end
   end

   // software control of crossover source and register-driven mode
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         xsrc_register <= 1'h0;
         xreg_auto <= 1'h1;
         xreg_cross <= 1'h0;
      end else if (bus_wr && sel_ctrl) begin
         xsrc_register <= wb_dat_i[`PSSD_CTRL_XSRC_BIT];
         xreg_auto <= wb_dat_i[`PSSD_CTRL_XAUTO_BIT];
         xreg_cross <= wb_dat_i[`PSSD_CTRL_XCROSS_BIT];
      end
   end

   // derived port defaults
   wire p1_an = effective.p1_autoneg;
   wire p1_spd = effective.p1_speed;
   wire p1_dup = effective.p1_duplex;
   wire p1_man = effective.port1_manual_pause_default;
   wire p1_fc = effective.port1_pause_enable_default;
   wire [2:0] p1_profile = p1_an ? `PSSD_PROFILE_ALL : {1'h0, p1_spd, p1_dup};
   // register control overrides both crossover straps
   wire x_from_straps = !xsrc_register;
   pssd_defaults_t next_defaults;
   always_comb begin
      next_defaults.link_rate_low_bit = p1_spd; // see RULE_01
      next_defaults.duplex_mode_bit = p1_dup; // see RULE_02
      next_defaults.profile_mode = p1_profile; // see RULE_01 see RULE_02
      next_defaults.adv_10_half = p1_an || !p1_spd; // see RULE_01
      next_defaults.adv_10_full = p1_dup && (p1_an || !p1_spd); // see RULE_02
      next_defaults.adv_sym_pause = !p1_man && p1_fc; // see RULE_07
      next_defaults.adv_asym_pause = !p1_man && p1_fc; // see RULE_05 see RULE_07
      next_defaults.port1_backpressure_enable = effective.port1_backpressure_default; // see RULE_03
      next_defaults.port1_tx_pause_enable = p1_fc; // see RULE_04
      next_defaults.port1_rx_pause_enable = p1_fc; // see RULE_04
      next_defaults.port1_manual_pause_select = p1_man; // see RULE_06
      next_defaults.hardware_config_reg_p2_crossover_state = effective.p2_auto_crossover; // see RULE_08
      next_defaults.p2_negotiation_enable_bit = effective.p2_autoneg; // see RULE_11
      if (x_from_straps) begin // see RULE_09
         next_defaults.p2_crossover_auto = effective.p2_auto_crossover;
         next_defaults.p2_crossover_forced_cross =
            !effective.p2_auto_crossover && effective.p2_manual_crossover; // see RULE_10
      end else begin
         next_defaults.p2_crossover_auto = xreg_auto;
         next_defaults.p2_crossover_forced_cross = !xreg_auto && xreg_cross;
      end
   end

   // defaults register, valid from the second run-state cycle on
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         port_defaults <= '0;
      end else begin
         port_defaults <= next_defaults;
      end
   end

   // ready once the latched set has been applied
   assign straps_ready = (state == PSSD_RUN); // see RULE_15

   // read data selection
   wire [31:0] rd_ctrl = {29'h0, xreg_cross, xreg_auto, xsrc_register};
   wire [31:0] rd_status = {14'h0, eeprom_active, straps_ready, 7'h0, effective};
   // defaults word is 17 bits wide, padded up to the bus width
   wire [31:0] rd_defaults = {15'h0, port_defaults};
   wire [31:0] rd_latched = {23'h0, latched};
   wire [31:0] rd_data = sel_ctrl ? rd_ctrl :
                         sel_status ? rd_status :
                         sel_defaults ? rd_defaults :
                         sel_latched ? rd_latched : 32'h0;

   // wishbone slave: one-cycle registered ack, held off until ready
   // read data is registered at the taking edge and stands until the next read
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wb_ack_o <= 1'h0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= bus_req; // see RULE_15
         if (bus_req && !wb_we_i) begin
            wb_dat_o <= rd_data;
         end
      end
   end

   // checks
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   rate_default_a: assert property (straps_ready && $past(straps_ready) |-> // see RULE_01
      port_defaults.link_rate_low_bit == $past(effective.p1_speed))
      else $error("link rate default does not follow rate strap");
   duplex_default_a: assert property (straps_ready && $past(straps_ready) |-> // see RULE_02
      port_defaults.duplex_mode_bit == $past(effective.p1_duplex))
      else $error("duplex default does not follow duplex strap");
   backpressure_copy_a: assert property (straps_ready ##1 straps_ready |-> // see RULE_03
      port_defaults.port1_backpressure_enable == $past(effective.port1_backpressure_default))
      else $error("backpressure default mismatch");
   pause_copy_a: assert property (straps_ready ##1 straps_ready |-> // see RULE_04
      port_defaults.port1_tx_pause_enable == port_defaults.port1_rx_pause_enable &&
      port_defaults.port1_tx_pause_enable == $past(effective.port1_pause_enable_default))
      else $error("pause enables do not match pause strap");
   asym_pause_a: assert property (straps_ready ##1 straps_ready |-> // see RULE_05
      port_defaults.adv_asym_pause == $past(p1_fc && !p1_man))
      else $error("asymmetric pause advert mismatch");
   manual_pause_a: assert property (straps_ready ##1 straps_ready |-> // see RULE_06
      port_defaults.port1_manual_pause_select == $past(p1_man))
      else $error("manual pause select mismatch");
   pause_advert_a: assert property ($past(p1_man) && straps_ready ##0 $past(straps_ready) |-> // see RULE_07
      !port_defaults.adv_sym_pause && !port_defaults.adv_asym_pause)
      else $error("pause advert set while manual pause strap high");
   pin_capture_a: assert property (state == PSSD_LATCH |=> // see RULE_08
      latched.p2_auto_crossover == $past(pin_sync))
      else $error("crossover pin not latched");
   cross_mode_a: assert property (straps_ready && x_from_straps && !effective.p2_auto_crossover // see RULE_10
      ##1 straps_ready |-> port_defaults.p2_crossover_forced_cross == $past(effective.p2_manual_crossover))
      else $error("manual crossover strap not applied");
   cross_source_a: assert property (straps_ready && xsrc_register ##1 straps_ready |-> // see RULE_09
      port_defaults.p2_crossover_auto == $past(xreg_auto))
      else $error("straps used while register control selected");
   p2_autoneg_a: assert property (straps_ready ##1 straps_ready |-> // see RULE_11
      port_defaults.p2_negotiation_enable_bit == $past(effective.p2_autoneg))
      else $error("port2 negotiation default mismatch");
   eeprom_load_a: assert property (straps_ready && eeprom_load_valid && eeprom_usable |=> // see RULE_12
      effective == $past(eeprom_straps) && eeprom_active)
      else $error("eeprom values not applied");
   revert_a: assert property (refresh_cmd && !eeprom_usable && !(state == PSSD_LATCH) |=> // see RULE_13
      effective == latched && !eeprom_active)
      else $error("straps did not revert to latched values");
   latch_stable_a: assert property (straps_ready ##1 straps_ready |-> $stable(latched)) // see RULE_14
      else $error("latched straps changed after capture");
   ack_ready_a: assert property (wb_ack_o |-> $past(straps_ready)) // see RULE_15
      else $error("bus answered before straps applied");
endmodule
`default_nettype wire

/* File: inc/pssd_defines.svh */
// offsets, field positions, strap defaults and timing counts for the soft-strap block
`ifndef PSSD_DEFINES_SVH
`define PSSD_DEFINES_SVH
// register byte offsets on the wishbone bus
`define PSSD_CTRL_OFS 4'h0
`define PSSD_STATUS_OFS 4'h4
`define PSSD_DEFAULTS_OFS 4'h8
`define PSSD_LATCHED_OFS 4'hC
// control register fields
`define PSSD_CTRL_XSRC_BIT 0
`define PSSD_CTRL_XAUTO_BIT 1
`define PSSD_CTRL_XCROSS_BIT 2
`define PSSD_CTRL_RELOAD_BIT 8
`define PSSD_CTRL_DIGRST_BIT 9
// status register fields
`define PSSD_STAT_READY_BIT 16
`define PSSD_STAT_EEPROM_BIT 17
// tie-off strap defaults
`define PSSD_P1_SPEED_DEF 1'h1
`define PSSD_P1_DUPLEX_DEF 1'h1
`define PSSD_P1_AUTONEG_DEF 1'h1
`define PSSD_P1_BP_DEF 1'h1
`define PSSD_P1_PAUSE_DEF 1'h1
`define PSSD_P1_MANUAL_DEF 1'h0
`define PSSD_P2_MANUAL_X_DEF 1'h0
`define PSSD_P2_AUTONEG_DEF 1'h1
// profile field value when negotiation is on: all capable
`define PSSD_PROFILE_ALL 3'h7
// synchroniser settle count: the settle state lasts this count plus one cycles before the pin strap is latched
`define PSSD_SETTLE_CYCLES 2'h2
`endif

/* File: inc/pssd_pkg.sv */
// types shared by the soft-strap default block
package pssd_pkg;
   // one set of soft-strap values
   typedef struct packed {
      logic p1_speed;
      logic p1_duplex;
      logic p1_autoneg;
      logic port1_backpressure_default;
      logic port1_pause_enable_default;
      logic port1_manual_pause_default;
      logic p2_auto_crossover;
      logic p2_manual_crossover;
      logic p2_autoneg;
   } pssd_strap_t;
   // reset defaults handed to the port registers
   typedef struct packed {
      logic link_rate_low_bit;
      logic duplex_mode_bit;
      logic [2:0] profile_mode;
      logic adv_10_full;
      logic adv_10_half;
      logic adv_sym_pause;
      logic adv_asym_pause;
      logic port1_backpressure_enable;
      logic port1_tx_pause_enable;
      logic port1_rx_pause_enable;
      logic port1_manual_pause_select;
      logic hardware_config_reg_p2_crossover_state;
      logic p2_negotiation_enable_bit;
      logic p2_crossover_auto;
      logic p2_crossover_forced_cross;
   } pssd_defaults_t;
   // capture sequence, gray coded
   typedef enum logic [1:0] {
      PSSD_SETTLE = 2'h0,
      PSSD_LATCH = 2'h1,
      PSSD_RUN = 2'h3
   } pssd_state_t;
endpackage

/* File: bench/pssd_strap_source.sv */
// behavioural model of the crossover strap pin and the serial eeprom loader
`timescale 1ns/1ps
`default_nettype none
module pssd_strap_source (
   input wire logic core_clk,
   output logic port2_crossover_strap_pin,
   output logic eeprom_present,
   output logic eeprom_erased,
   output logic eeprom_load_valid,
   output pssd_pkg::pssd_strap_t eeprom_straps
);
   import pssd_pkg::*;
   // idle loader: nothing attached, strap pin pulled high
   initial begin
      port2_crossover_strap_pin = 1'h1;
      eeprom_present = 1'h0;
      eeprom_erased = 1'h0;
      eeprom_load_valid = 1'h0;
      eeprom_straps = 9'h0AA;
   end
   // pin level; asynchronous, so it may move between edges
   task automatic set_pin(input logic v);
      port2_crossover_strap_pin = v;
   endtask
   // attach, remove or blank the eeprom
   task automatic attach(input logic p, input logic e);
      @(posedge core_clk);
      eeprom_present <= p;
      eeprom_erased <= e;
   endtask
   // one-cycle strap image, then inverted data so stale bits never pass as valid
   task automatic load(input pssd_strap_t s);
      @(posedge core_clk);
      eeprom_load_valid <= 1'h1;
      eeprom_straps <= s;
      @(posedge core_clk);
      eeprom_load_valid <= 1'h0;
      eeprom_straps <= ~s;
   endtask
endmodule
`default_nettype wire

/* File: bench/test_port_soft_strap_defaults.sv */
// self-checking bench for the soft-strap default block
`timescale 1ns/1ps
`default_nettype none
module test_port_soft_strap_defaults;
   import pssd_pkg::*;
   logic core_clk, resetn, pin, e_pres, e_era, e_val;
   pssd_strap_t e_str;
   logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, straps_ready;
   logic [3:0] wb_adr_i, wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   pssd_defaults_t port_defaults;
   logic [2:0] ctrl; // bench copy of the control bits
   logic [3:0] wsel; // byte lanes for the next bus cycle
   int fails, n_checks;
   pssd_top i_pssd_top (.core_clk(core_clk), .resetn(resetn), .port2_crossover_strap_pin(pin),
      .eeprom_present(e_pres), .eeprom_erased(e_era), .eeprom_load_valid(e_val),
      .eeprom_straps(e_str), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .port_defaults(port_defaults), .straps_ready(straps_ready));
   pssd_strap_source i_pssd_strap_source (.core_clk(core_clk), .port2_crossover_strap_pin(pin),
      .eeprom_present(e_pres), .eeprom_erased(e_era), .eeprom_load_valid(e_val),
      .eeprom_straps(e_str));
   // 50 MHz clock
   initial begin
      core_clk = 1'h0;
      forever #10 core_clk = ~core_clk;
   end
   // compare one value and count it
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one classic wishbone cycle; waits for ack under a bound
   task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= wsel;
      @(posedge core_clk);
      while (wb_ack_o !== 1'h1 && n < 50) begin
         @(posedge core_clk);
         n++;
      end
      if (n == 50) chk("ack", 32'h1, 32'h0);
      rd = wb_dat_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
      wb_we_i <= 1'h0;
   endtask
   // expected port defaults from a strap set and the control bits
   function automatic pssd_defaults_t exp_def(input pssd_strap_t s, input logic [2:0] c);
      pssd_defaults_t d;
      logic open;
      open = s.p1_autoneg | ~s.p1_speed;
      d.link_rate_low_bit = s.p1_speed;
      d.duplex_mode_bit = s.p1_duplex;
      d.profile_mode = s.p1_autoneg ? 3'h7 : {1'h0, s.p1_speed, s.p1_duplex};
      d.adv_10_full = s.p1_duplex & open;
      d.adv_10_half = open;
      d.adv_sym_pause = s.port1_pause_enable_default & ~s.port1_manual_pause_default;
      d.adv_asym_pause = d.adv_sym_pause;
      d.port1_backpressure_enable = s.port1_backpressure_default;
      d.port1_tx_pause_enable = s.port1_pause_enable_default;
      d.port1_rx_pause_enable = s.port1_pause_enable_default;
      d.port1_manual_pause_select = s.port1_manual_pause_default;
      d.hardware_config_reg_p2_crossover_state = s.p2_auto_crossover;
      d.p2_negotiation_enable_bit = s.p2_autoneg;
      d.p2_crossover_auto = c[0] ? c[1] : s.p2_auto_crossover;
      d.p2_crossover_forced_cross = c[0] ? (~c[1] & c[2]) :
         (~s.p2_auto_crossover & s.p2_manual_crossover);
      return d;
   endfunction
   // let updates land, then compare defaults and the status word
   task automatic expect_state(input pssd_strap_t s, input logic ee);
      repeat (4) @(posedge core_clk);
      #1;
      chk("port_defaults", 32'(exp_def(s, ctrl)), 32'(port_defaults));
      wb(1'h0, 4'h4, 32'h0);
      chk("status", {14'h0, ee, 1'h1, 7'h0, s}, rd);
   endtask
   // pin reset with a given strap pin level; outputs stay low while held
   task automatic pin_reset(input logic p);
      int n;
      n = 0;
      i_pssd_strap_source.set_pin(p);
      resetn <= 1'h0;
      repeat (5) @(posedge core_clk);
      chk("ready in reset", 32'h0, 32'(straps_ready));
      chk("defaults in reset", 32'h0, 32'(port_defaults));
      resetn <= 1'h1;
      while (straps_ready !== 1'h1 && n < 40) begin
         @(posedge core_clk);
         n++;
      end
      chk("ready", 32'h1, 32'(straps_ready));
      ctrl = 3'h2;
   endtask
   // tie-off defaults and pin capture after power-on, unmapped read
   task automatic t_power_on;
      pin_reset(1'h1);
      expect_state(9'h1F5, 1'h0);
      wb(1'h0, 4'hC, 32'h0);
      chk("latched", 32'h1F5, rd);
      wb(1'h0, 4'h8, 32'h0);
      chk("defaults word", 32'(exp_def(9'h1F5, ctrl)), rd);
      wb(1'h0, 4'h0, 32'h0);
      chk("control", 32'h2, rd);
      wb(1'h0, 4'h2, 32'h0);
      chk("unmapped", 32'h0, rd);
      $display("test power_on done");
   endtask
   // eeprom images override straps; pause adverts follow the manual pause strap
   task automatic t_eeprom;
      i_pssd_strap_source.attach(1'h1, 1'h0);
      i_pssd_strap_source.load(9'h092);
      expect_state(9'h092, 1'h1);
      i_pssd_strap_source.load(9'h13D);
      expect_state(9'h13D, 1'h1);
      i_pssd_strap_source.load(9'h092);
      expect_state(9'h092, 1'h1);
      $display("test eeprom done");
   endtask
   // crossover straps act only while the strap source is selected
   task automatic t_crossover;
      logic [2:0] tbl [3];
      tbl = '{3'h3, 3'h5, 3'h4};
      foreach (tbl[i]) begin
         ctrl = tbl[i];
         wb(1'h1, 4'h0, {29'h0, tbl[i]});
         expect_state(9'h092, 1'h1);
      end
      // byte lane 0 off: the control bits must keep their last value
      wsel = 4'h2;
      wb(1'h1, 4'h0, 32'h5);
      wsel = 4'hF;
      wb(1'h0, 4'h0, 32'h0);
      chk("control lanes", 32'h4, rd);
      ctrl = 3'h2;
      wb(1'h1, 4'h0, 32'h2);
      expect_state(9'h092, 1'h1);
      $display("test crossover done");
   endtask
   // reload and digital reset fall back to latched straps, pin not resampled
   task automatic t_revert;
      i_pssd_strap_source.set_pin(1'h0);
      i_pssd_strap_source.attach(1'h1, 1'h1);
      wb(1'h1, 4'h0, 32'h102);
      expect_state(9'h1F5, 1'h0);
      i_pssd_strap_source.load(9'h13D);
      expect_state(9'h1F5, 1'h0);
      i_pssd_strap_source.attach(1'h1, 1'h0);
      i_pssd_strap_source.load(9'h13D);
      i_pssd_strap_source.attach(1'h0, 1'h0);
      wb(1'h1, 4'h0, 32'h202);
      expect_state(9'h1F5, 1'h0);
      $display("test revert done");
   endtask
   // a pin reset captures the new pin level
   task automatic t_repin;
      pin_reset(1'h0);
      expect_state(9'h1F1, 1'h0);
      wb(1'h0, 4'hC, 32'h0);
      chk("latched", 32'h1F1, rd);
      $display("test repin done");
   endtask
   // counts, verdict and end of run
   task automatic summarize;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // watchdog well beyond the expected few hundred cycles
   initial begin
      #1000000;
      fails++;
      summarize();
   end
   // main sequence
   initial begin
      fails = 0;
      n_checks = 0;
      ctrl = 3'h2;
      resetn = 1'h0;
      wb_cyc_i = 1'h0;
      wb_stb_i = 1'h0;
      wb_we_i = 1'h0;
      wb_adr_i = 4'h0;
      wb_sel_i = 4'hF;
      wsel = 4'hF;
      wb_dat_i = 32'h0;
      t_power_on();
      t_eeprom();
      t_crossover();
      t_revert();
      t_repin();
      summarize();
   end
endmodule
`default_nettype wire
